//--- common/link_mon_pkg.sv
package link_mon_pkg;
    // register offsets: printed offsets are not all multiples of four
    localparam logic [7:0] LINK_ERR_CTRL_IDX = 8'hB9;
    localparam logic [7:0] PARITY_CTRL_IDX = 8'hB6;
    localparam logic [7:0] LOCK_STATUS_IDX = 8'hC0;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'hC1;
    localparam logic [7:0] IRQ_ENABLE_IDX = 8'hC2;
    localparam logic [7:0] IRQ_CLEAR_IDX = 8'hC3;
    localparam logic [7:0] ADAPT_WAIT_IDX = 8'hC4;
    localparam logic [7:0] LINK_ERR_CTRL_RST = 8'h03;
    localparam logic [7:0] PARITY_CTRL_RST = 8'h18;
    localparam logic [7:0] ADAPT_WAIT_RST = 8'h10;
    localparam int LIMIT_LSB = 0;
    localparam int COUNT_EN_BIT = 4;
    localparam int ADAPT_MASK_BIT = 5;
    localparam int IGN_LOSS_BIT = 3;
    localparam int IGN_LOCK_BIT = 4;
    localparam int RETAIN_BIT = 5;
    localparam logic [7:0] LINK_ERR_CTRL_WMASK = 8'h3F;
    localparam logic [7:0] PARITY_CTRL_WMASK = 8'h38;
    // interrupt bits: lock lost, lock gained, parity error
    localparam int IRQ_LOST_BIT = 0;
    localparam int IRQ_GAIN_BIT = 1;
    localparam int IRQ_PAR_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : link_mon_pkg

//--- design/link_error_lock_monitor.sv
`timescale 1ns/1ps
module link_error_lock_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_err_in,
    input wire logic parity_err_in,
    input wire logic cdr_lock_in,
    input wire logic equalizer_strobe_filter_update,
    output logic rx_lock,
    output logic irq
);
    // pin inputs, two-flop synchronisers
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic link_err_s;
    logic par_err_s;
    logic cdr_lock_s;
    logic filt_upd_s;
    logic filt_upd_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            filt_upd_prev_q <= 1'b0;
        end else begin
            sync1_q <= {equalizer_strobe_filter_update, cdr_lock_in,
                        parity_err_in, link_err_in};
            sync2_q <= sync1_q;
            filt_upd_prev_q <= sync2_q[3];
        end
    end

    assign link_err_s = sync2_q[0];
    assign par_err_s = sync2_q[1];
    assign cdr_lock_s = sync2_q[2];
    assign filt_upd_s = sync2_q[3] && !filt_upd_prev_q;

    function automatic logic idx_hit(input logic [11:0] a,
                                     input logic [7:0] idx);
        idx_hit = (a == {2'b00, idx, 2'b00});
    endfunction : idx_hit

    // registers
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] par_q, par_d;
    logic [7:0] wait_q, wait_d;
    localparam int IRQ_W_L = link_mon_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] ien_q, ien_d;
    logic [IRQ_W_L-1:0] ists_q, ists_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [3:0] err_cnt_q, err_cnt_d;
    logic [7:0] par_cnt_q, par_cnt_d;
    logic [7:0] wait_cnt_q, wait_cnt_d;
    logic rx_lock_d, irq_d;
    logic wr_acc, rd_acc, mapped;
    logic err_hit, err_raw, par_loss, par_block;
    logic [IRQ_W_L-1:0] ev;

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite && !pready;
    assign mapped = idx_hit(paddr, link_mon_pkg::LINK_ERR_CTRL_IDX)
        || idx_hit(paddr, link_mon_pkg::PARITY_CTRL_IDX)
        || idx_hit(paddr, link_mon_pkg::LOCK_STATUS_IDX)
        || idx_hit(paddr, link_mon_pkg::IRQ_STATUS_IDX)
        || idx_hit(paddr, link_mon_pkg::IRQ_ENABLE_IDX)
        || idx_hit(paddr, link_mon_pkg::IRQ_CLEAR_IDX)
        || idx_hit(paddr, link_mon_pkg::ADAPT_WAIT_IDX);

    // error qualification
    always_comb begin
        par_loss = par_err_s && !par_q[link_mon_pkg::IGN_LOSS_BIT];
        par_block = par_err_s && !par_q[link_mon_pkg::IGN_LOCK_BIT];
        err_raw = link_err_s || par_loss;
        err_hit = err_raw && !(ctrl_q[link_mon_pkg::ADAPT_MASK_BIT]
                  && wait_cnt_q != 8'h00);
    end

    // lock and counters
    always_comb begin
        err_cnt_d = err_cnt_q;
        rx_lock_d = rx_lock;
        par_cnt_d = par_cnt_q;
        wait_cnt_d = wait_cnt_q;
        if (filt_upd_s) begin
            wait_cnt_d = wait_q;
        end else if (wait_cnt_q != 8'h00) begin
            wait_cnt_d = wait_cnt_q - 8'h01;
        end
        if (!rx_lock) begin
            err_cnt_d = 4'h0;
            rx_lock_d = cdr_lock_s && !par_block;
        end else if (!cdr_lock_s) begin
            rx_lock_d = 1'b0;
        end else if (!ctrl_q[link_mon_pkg::COUNT_EN_BIT]) begin
            err_cnt_d = 4'h0;
            if (err_hit) begin
                rx_lock_d = 1'b0;
            end
        end else if (err_hit) begin
            err_cnt_d = err_cnt_q + 4'h1;
            if (err_cnt_q + 4'h1 >= ctrl_q[3:0]) begin
                rx_lock_d = 1'b0;
            end
        end
        if (par_err_s && par_cnt_q != 8'hFF) begin
            par_cnt_d = par_cnt_q + 8'h01;
        end
        if (!rx_lock && !par_q[link_mon_pkg::RETAIN_BIT]) begin
            par_cnt_d = 8'h00;
        end
    end

    // events, bus
    always_comb begin
        ev = '0;
        ev[link_mon_pkg::IRQ_LOST_BIT] = rx_lock && !rx_lock_d;
        ev[link_mon_pkg::IRQ_GAIN_BIT] = !rx_lock && rx_lock_d;
        ev[link_mon_pkg::IRQ_PAR_BIT] = par_err_s;
        ctrl_d = ctrl_q;
        par_d = par_q;
        wait_d = wait_q;
        ien_d = ien_q;
        ists_d = ists_q;
        prdata_d = prdata;
        pready_d = psel && penable && !pready;
        pslverr_d = psel && penable && !pready && !mapped;
        if (wr_acc) begin
            if (idx_hit(paddr, link_mon_pkg::LINK_ERR_CTRL_IDX)) begin
                ctrl_d = pwdata[7:0] & link_mon_pkg::LINK_ERR_CTRL_WMASK;
            end
            if (idx_hit(paddr, link_mon_pkg::PARITY_CTRL_IDX)) begin
                par_d = pwdata[7:0] & link_mon_pkg::PARITY_CTRL_WMASK;
            end
            if (idx_hit(paddr, link_mon_pkg::ADAPT_WAIT_IDX)) begin
                wait_d = pwdata[7:0];
            end
            if (idx_hit(paddr, link_mon_pkg::IRQ_ENABLE_IDX)) begin
                ien_d = pwdata[IRQ_W_L-1:0];
            end
            if (idx_hit(paddr, link_mon_pkg::IRQ_CLEAR_IDX)) begin
                ists_d = ists_q & ~pwdata[IRQ_W_L-1:0];
            end
        end
        ists_d = ists_d | ev;
        if (rd_acc) begin
            prdata_d = link_mon_pkg::UNMAPPED_DATA;
            if (idx_hit(paddr, link_mon_pkg::LINK_ERR_CTRL_IDX)) begin
                prdata_d = {24'h0, ctrl_q};
            end
            if (idx_hit(paddr, link_mon_pkg::PARITY_CTRL_IDX)) begin
                prdata_d = {24'h0, par_q};
            end
            if (idx_hit(paddr, link_mon_pkg::LOCK_STATUS_IDX)) begin
                prdata_d = {15'h0, rx_lock, par_cnt_q, 4'h0, err_cnt_q};
            end
            if (idx_hit(paddr, link_mon_pkg::IRQ_STATUS_IDX)) begin
                prdata_d = {29'h0, ists_q};
            end
            if (idx_hit(paddr, link_mon_pkg::IRQ_ENABLE_IDX)) begin
                prdata_d = {29'h0, ien_q};
            end
            if (idx_hit(paddr, link_mon_pkg::ADAPT_WAIT_IDX)) begin
                prdata_d = {24'h0, wait_q};
            end
        end
        irq_d = |(ists_d & ien_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= link_mon_pkg::LINK_ERR_CTRL_RST;
            par_q <= link_mon_pkg::PARITY_CTRL_RST;
            wait_q <= link_mon_pkg::ADAPT_WAIT_RST;
            ien_q <= '0;
            ists_q <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            err_cnt_q <= 4'h0;
            par_cnt_q <= 8'h00;
            wait_cnt_q <= 8'h00;
            rx_lock <= 1'b0;
            irq <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            par_q <= par_d;
            wait_q <= wait_d;
            ien_q <= ien_d;
            ists_q <= ists_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            err_cnt_q <= err_cnt_d;
            par_cnt_q <= par_cnt_d;
            wait_cnt_q <= wait_cnt_d;
            rx_lock <= rx_lock_d;
            irq <= irq_d;
        end
    end

    // bus, register, interrupt and error qualification checks
    pready_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn) pready |=> !pready)
        else $error("ready held longer than one cycle");
    pready_answer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    slverr_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn) pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    unmapped_data_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && !mapped |=> prdata == link_mon_pkg::UNMAPPED_DATA)
        else $error("unmapped read returned data");
    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn) irq == |(ists_q & ien_q))
        else $error("interrupt level wrong");
    lost_sticky_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ev[link_mon_pkg::IRQ_LOST_BIT]
        |=> ists_q[link_mon_pkg::IRQ_LOST_BIT])
        else $error("lock lost event not kept");
    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[7:6] == 2'b00 && par_q[7:6] == 2'b00 && par_q[2:0] == 3'b000)
        else $error("reserved control bits set");

    first_error_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_lock && cdr_lock_s && !ctrl_q[4] && err_hit |=> !rx_lock)
        else $error("lock kept after error with counting off");
    limit_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_lock && cdr_lock_s && ctrl_q[4] && err_hit
        && (err_cnt_q + 4'h1 >= ctrl_q[3:0]) |=> !rx_lock)
        else $error("lock kept at error limit");
    below_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_lock && cdr_lock_s && ctrl_q[4] && err_hit
        && (err_cnt_q + 4'h1 < ctrl_q[3:0]) |=> rx_lock)
        else $error("lock dropped below limit");
    wait_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[5] && wait_cnt_q != 8'h00 && !par_err_s |-> !err_hit)
        else $error("error seen in masked wait window");
    wait_unmask_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q[5] && link_err_s |-> err_hit)
        else $error("error lost with mask clear");
    par_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rx_lock && par_err_s && !par_q[4] |=> !rx_lock)
        else $error("lock gained despite parity error");
    par_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        par_q[3] && !link_err_s |-> !err_raw)
        else $error("ignored parity counted for loss");
    par_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rx_lock && !par_q[5] |=> par_cnt_q == 8'h00)
        else $error("parity count kept while unlocked");
    cnt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(rx_lock) |-> err_cnt_q == 4'h0)
        else $error("count not empty at new lock");
    err_watch_a: assert property (@(posedge pclk) disable iff (!presetn)
        link_err_s && !(ctrl_q[5] && wait_cnt_q != 8'h00) |-> err_hit)
        else $error("link error not watched");

    // lock and counter checks
    lock_gain_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !rx_lock && cdr_lock_s && !par_block |=> rx_lock)
        else $error("lock not gained");
    cdr_loss_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_lock && !cdr_lock_s |=> !rx_lock)
        else $error("lock kept without raw lock");
    count_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_lock && cdr_lock_s && ctrl_q[link_mon_pkg::COUNT_EN_BIT]
        && err_hit |=> err_cnt_q == $past(err_cnt_q) + 4'h1)
        else $error("error not counted");
    count_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rx_lock && cdr_lock_s && !ctrl_q[link_mon_pkg::COUNT_EN_BIT]
        |=> err_cnt_q == 4'h0)
        else $error("count kept with counting off");
    wait_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        filt_upd_s |=> wait_cnt_q == $past(wait_q))
        else $error("wait window not started");
    retain_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !rx_lock && par_q[link_mon_pkg::RETAIN_BIT] && !par_err_s
        |=> par_cnt_q == $past(par_cnt_q))
        else $error("parity count not retained");
    par_sat_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        par_cnt_q == 8'hFF && rx_lock |=> par_cnt_q == 8'hFF)
        else $error("parity count wrapped");
endmodule : link_error_lock_monitor

//--- verification/serializer_model.sv
`timescale 1ns/1ps
module serializer_model (
    input wire logic pclk,
    output logic link_err_in,
    output logic parity_err_in,
    output logic cdr_lock_in,
    output logic equalizer_strobe_filter_update
);
    initial begin
        link_err_in = 1'h0;
        parity_err_in = 1'h0;
        cdr_lock_in = 1'h0;
        equalizer_strobe_filter_update = 1'h0;
    end
    // drop and regain the raw link lock
    task automatic relock();
        @(posedge pclk) cdr_lock_in <= 1'h0;
        repeat (4) @(posedge pclk);
        cdr_lock_in <= 1'h1;
    endtask : relock
    // error pulses, optionally just after an equalizer update
    task automatic hit(input int n, input logic upd);
        @(posedge pclk) equalizer_strobe_filter_update <= upd;
        repeat (n) begin
            @(posedge pclk) link_err_in <= 1'h1;
            @(posedge pclk) link_err_in <= 1'h0;
            repeat (4) @(posedge pclk);
        end
        equalizer_strobe_filter_update <= 1'h0;
    endtask : hit
    task automatic par(input logic v);
        @(posedge pclk) parity_err_in <= v;
    endtask : par
endmodule : serializer_model

//--- verification/link_error_lock_monitor_tb.sv
`timescale 1ns/1ps
module link_error_lock_monitor_tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, se, rx_lock, irq;
    logic link_err_in, parity_err_in, cdr_lock_in, upd;
    int err_count = 0;
    int n_checks = 0;
    always #20 pclk = ~pclk;
    link_error_lock_monitor i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_err_in(link_err_in),
        .parity_err_in(parity_err_in), .cdr_lock_in(cdr_lock_in),
        .equalizer_strobe_filter_update(upd), .rx_lock(rx_lock),
        .irq(irq));
    serializer_model i_ser (.pclk(pclk), .link_err_in(link_err_in),
        .parity_err_in(parity_err_in), .cdr_lock_in(cdr_lock_in),
        .equalizer_strobe_filter_update(upd));
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk) penable <= 1'h1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            err_count++;
            finish_test();
        end
    endtask : apb
    task automatic lock_is(input logic v);
        for (int i = 0; i < 60 && rx_lock !== v; i++) @(posedge pclk);
        chk({31'h0, rx_lock}, {31'h0, v});
        if (rx_lock !== v) finish_test();
    endtask : lock_is
    task automatic lost_seen();
        apb(1'h0, link_mon_pkg::IRQ_STATUS_IDX, 8'h00);
        chk(rd & 32'h1, 32'h1);
    endtask : lost_seen
    task automatic t_reset();
        apb(1'h0, link_mon_pkg::LINK_ERR_CTRL_IDX, 8'h00);
        chk(rd, 32'h3);
        apb(1'h0, link_mon_pkg::PARITY_CTRL_IDX, 8'h00);
        chk(rd, 32'h18);
        apb(1'h0, 8'h00, 8'h00);
        chk({rd[30:0], se}, 32'h1);
    endtask : t_reset
    task automatic t_first();
        i_ser.relock();
        lock_is(1'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, link_mon_pkg::IRQ_ENABLE_IDX, 8'h01);
        i_ser.hit(1, 1'h0);
        lost_seen();
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, link_mon_pkg::IRQ_CLEAR_IDX, 8'h07);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_first
    task automatic t_limit();
        apb(1'h1, link_mon_pkg::LINK_ERR_CTRL_IDX, 8'h13);
        i_ser.relock();
        lock_is(1'h1);
        apb(1'h1, link_mon_pkg::IRQ_CLEAR_IDX, 8'h07);
        i_ser.hit(2, 1'h0);
        apb(1'h0, link_mon_pkg::LOCK_STATUS_IDX, 8'h00);
        chk(rd & 32'h1000F, 32'h10002);
        apb(1'h0, link_mon_pkg::IRQ_STATUS_IDX, 8'h00);
        chk(rd & 32'h1, 32'h0);
        i_ser.hit(1, 1'h0);
        lost_seen();
        i_ser.relock();
        lock_is(1'h1);
        apb(1'h0, link_mon_pkg::LOCK_STATUS_IDX, 8'h00);
        chk(rd & 32'hF, 32'h0);
    endtask : t_limit
    task automatic t_mask();
        apb(1'h1, link_mon_pkg::LINK_ERR_CTRL_IDX, 8'h20);
        i_ser.relock();
        lock_is(1'h1);
        apb(1'h1, link_mon_pkg::IRQ_CLEAR_IDX, 8'h07);
        i_ser.hit(1, 1'h1);
        apb(1'h0, link_mon_pkg::IRQ_STATUS_IDX, 8'h00);
        chk(rd & 32'h1, 32'h0);
        apb(1'h1, link_mon_pkg::LINK_ERR_CTRL_IDX, 8'h00);
        i_ser.hit(1, 1'h1);
        lost_seen();
    endtask : t_mask
    task automatic t_parity();
        apb(1'h1, link_mon_pkg::PARITY_CTRL_IDX, 8'h08);
        i_ser.par(1'h1);
        i_ser.relock();
        repeat (20) @(posedge pclk);
        chk({31'h0, rx_lock}, 32'h0);
        apb(1'h0, link_mon_pkg::LOCK_STATUS_IDX, 8'h00);
        chk(rd & 32'hFF00, 32'h0);
        i_ser.par(1'h0);
        lock_is(1'h1);
    endtask : t_parity
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_first();
        t_limit();
        t_mask();
        t_parity();
        finish_test();
    end
endmodule : link_error_lock_monitor_tb
